// ---- hw/xbs_regs.svh ----
// register offsets, field positions, reset values and codes of the external bus route select block
`ifndef XBS_REGS_SVH
`define XBS_REGS_SVH

// byte addresses on the register bus
`define XBS_ADDR_W          16
`define XBS_ROUTE_SEL_ADDR  16'h6c00
`define XBS_IRQ_STAT_ADDR   16'h6c04
`define XBS_IRQ_MASK_ADDR   16'h6c08
`define XBS_CTRL_ADDR       16'h6c0c

// route select fields
`define XBS_PAR_HOST_BIT    0
`define XBS_RSVD_RO_BIT     1
`define XBS_SERIAL_BIT      2
`define XBS_RSVD_RW_BIT     3
`define XBS_SEL_W           4

// control fields
`define XBS_TMO_EN_BIT      0

// peripheral index in every per-peripheral vector
`define XBS_NUM_PERIPH      3
`define XBS_P_MEM           0
`define XBS_P_UART          1
`define XBS_P_BSP           2

// reset values of software registers
`define XBS_MASK_RST        3'h0
`define XBS_STAT_RST        3'h0
`define XBS_TMO_EN_RST      1'h0

// bus answers
`define XBS_RESP_OKAY       2'h0
`define XBS_RESP_SLVERR     2'h2
`define XBS_WORD_ZERO       32'h0000_0000

`endif

// ---- hw/xbs_pkg.sv ----
// types shared by the external bus route select block
package xbs_pkg;
    typedef logic [2:0]  xbs_periph_vec_t;
    typedef logic [15:0] xbs_addr_t;
    typedef logic [31:0] xbs_word_t;
    typedef logic [3:0]  xbs_sel_t;
endpackage : xbs_pkg

// ---- hw/xbs_guard_if.sv ----
// signals between the route register and the per-peripheral guard
`timescale 1ns/10ps
interface xbs_guard_if;
    xbs_pkg::xbs_periph_vec_t selected;   // peripheral chosen by the route bits
    xbs_pkg::xbs_periph_vec_t access;     // access strobe toward each peripheral
    logic                     tmo_en;     // peripheral time-out enable
    xbs_pkg::xbs_periph_vec_t clk_en;     // clock enable per peripheral
    xbs_pkg::xbs_periph_vec_t bus_err;    // one-cycle bus error per peripheral

    modport ctrl  (output selected, output access, output tmo_en, input clk_en, input bus_err);
    modport guard (input selected, input access, input tmo_en, output clk_en, output bus_err);
endinterface : xbs_guard_if

// ---- hw/xbs_guard.sv ----
// clock gating and bus error detection for the muxed peripherals
`timescale 1ns/10ps
`include "xbs_regs.svh"
module xbs_guard (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  ce,
    xbs_guard_if.guard g
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    genvar i;
    generate
        for (i = 0; i < `XBS_NUM_PERIPH; i = i + 1) begin : g_periph
            logic clk_en_reg;
            logic bus_err_reg;

            // clock follows the route bits; unselected blocks burn no power
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    clk_en_reg <= 1'b0;
                end else if (ce) begin
                    clk_en_reg <= g.selected[i];
                end
            end

            // access to a disabled block errors only with time-out enabled
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    bus_err_reg <= 1'b0;
                end else if (ce) begin
                    bus_err_reg <= g.access[i] && !g.selected[i] && g.tmo_en;
                end
            end

            assign g.clk_en[i]  = clk_en_reg;
            assign g.bus_err[i] = bus_err_reg;

            a_gate_follows_sel:
            assert property ($past(ce) && $past(aresetn) |-> clk_en_reg == $past(g.selected[i]))
                else $error("clock enable does not follow selection");

            a_err_on_disabled:
            assert property (ce && g.access[i] && !g.selected[i] && g.tmo_en |=> bus_err_reg)
                else $error("access to disabled peripheral gave no bus error");

            a_err_has_cause:
            assert property (bus_err_reg && $past(aresetn) && $past(ce)
                             |-> $past(g.access[i] && !g.selected[i] && g.tmo_en))
                else $error("bus error without disabled access");
        end
    endgenerate
endmodule : xbs_guard

// ---- hw/xbs_route_top.sv ----
// external bus route select: strap capture, route register, AXI4-Lite slave, interrupt
`timescale 1ns/10ps
`include "xbs_regs.svh"
module xbs_route_top (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    // straps
    input  wire logic                     strap_pin_a,
    input  wire logic                     strap_pin_b,
    // accesses toward the muxed peripherals
    input  wire xbs_pkg::xbs_periph_vec_t periph_access,
    // route outputs
    output logic                          parallel_route_mem,
    output logic                          host_route_mux8,
    output logic                          serial_route_bsp,
    output xbs_pkg::xbs_periph_vec_t      periph_clk_en,
    output xbs_pkg::xbs_periph_vec_t      periph_bus_err,
    output logic                          irq,
    // AXI4-Lite slave
    input  wire xbs_pkg::xbs_addr_t       s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire xbs_pkg::xbs_word_t       s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire xbs_pkg::xbs_addr_t       s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output xbs_pkg::xbs_word_t            s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    xbs_pkg::xbs_sel_t        sel_reg;      // route select register
    xbs_pkg::xbs_periph_vec_t stat_reg;     // sticky bus error status
    xbs_pkg::xbs_periph_vec_t mask_reg;     // interrupt mask
    logic                     tmo_en_reg;   // peripheral time-out enable
    logic                     irq_reg;

    xbs_pkg::xbs_addr_t       aw_addr_reg;
    logic                     aw_full_reg;
    xbs_pkg::xbs_word_t       w_data_reg;
    logic [3:0]               w_strb_reg;
    logic                     w_full_reg;
    logic                     awready_reg;
    logic                     wready_reg;
    logic                     bvalid_reg;
    logic [1:0]               bresp_reg;
    logic                     arready_reg;
    logic                     rvalid_reg;
    logic [1:0]               rresp_reg;
    xbs_pkg::xbs_word_t       rdata_reg;

    logic                     do_write;
    logic                     wr_sel;
    logic                     wr_stat;
    logic                     wr_mask;
    logic                     wr_ctrl;
    logic                     wr_hit;
    logic                     ar_take;
    xbs_pkg::xbs_word_t       rd_word;
    logic                     rd_hit;

    xbs_guard_if gi ();

    // peripheral selection seen by the guard
    assign gi.selected[`XBS_P_MEM]  = sel_reg[`XBS_PAR_HOST_BIT];
    assign gi.selected[`XBS_P_UART] = !sel_reg[`XBS_SERIAL_BIT];
    assign gi.selected[`XBS_P_BSP]  = sel_reg[`XBS_SERIAL_BIT];
    assign gi.access                = periph_access;
    assign gi.tmo_en                = tmo_en_reg;

    xbs_guard u_guard (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .g       (gi.guard)
    );

    // write decode: one write at a time, taken once both halves are held
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_sel   = do_write && (aw_addr_reg == `XBS_ROUTE_SEL_ADDR);
    assign wr_stat  = do_write && (aw_addr_reg == `XBS_IRQ_STAT_ADDR);
    assign wr_mask  = do_write && (aw_addr_reg == `XBS_IRQ_MASK_ADDR);
    assign wr_ctrl  = do_write && (aw_addr_reg == `XBS_CTRL_ADDR);
    assign wr_hit   = wr_sel || wr_stat || wr_mask || wr_ctrl;
    assign ar_take  = s_axi_arvalid && arready_reg;

    // route select register; straps load it for as long as reset is held,
    // so the level present at the last reset edge is the one kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg                   <= '0;
            sel_reg[`XBS_PAR_HOST_BIT] <= strap_pin_a;
            sel_reg[`XBS_SERIAL_BIT]   <= strap_pin_b;
        end else if (ce && wr_sel && w_strb_reg[0]) begin
            // bits stay writable; a late mode change is software's hazard
            sel_reg[`XBS_PAR_HOST_BIT] <= w_data_reg[`XBS_PAR_HOST_BIT];
            sel_reg[`XBS_SERIAL_BIT]   <= w_data_reg[`XBS_SERIAL_BIT];
            sel_reg[`XBS_RSVD_RW_BIT]  <= w_data_reg[`XBS_RSVD_RW_BIT];
        end
    end

    // time-out enable and interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_en_reg <= `XBS_TMO_EN_RST;
            mask_reg   <= `XBS_MASK_RST;
        end else if (ce) begin
            if (wr_ctrl && w_strb_reg[0]) begin
                tmo_en_reg <= w_data_reg[`XBS_TMO_EN_BIT];
            end
            if (wr_mask && w_strb_reg[0]) begin
                mask_reg <= w_data_reg[`XBS_NUM_PERIPH-1:0];
            end
        end
    end

    // sticky status: write one to clear, a new error in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= `XBS_STAT_RST;
        end else if (ce) begin
            if (wr_stat && w_strb_reg[0]) begin
                stat_reg <= (stat_reg & ~w_data_reg[`XBS_NUM_PERIPH-1:0]) | gi.bus_err;
            end else begin
                stat_reg <= stat_reg | gi.bus_err;
            end
        end
    end

    // level interrupt, registered so the pin never glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_reg) begin
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
                awready_reg <= 1'b1;
            end else if (!aw_full_reg) begin
                awready_reg <= 1'b1;
            end
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && wready_reg) begin
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
                wready_reg <= 1'b1;
            end else if (!w_full_reg) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // write response; unmapped addresses answer with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `XBS_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? `XBS_RESP_OKAY : `XBS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read mux; unused bits read as zero, reserved bit 3 reads back as written, bit 1 is hard zero
    always_comb begin
        rd_word = `XBS_WORD_ZERO;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `XBS_ROUTE_SEL_ADDR: begin
                rd_word[`XBS_SEL_W-1:0] = sel_reg;
            end
            `XBS_IRQ_STAT_ADDR: begin
                rd_word[`XBS_NUM_PERIPH-1:0] = stat_reg;
            end
            `XBS_IRQ_MASK_ADDR: begin
                rd_word[`XBS_NUM_PERIPH-1:0] = mask_reg;
            end
            `XBS_CTRL_ADDR: begin
                rd_word[`XBS_TMO_EN_BIT] = tmo_en_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel: one read in flight, answered the edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `XBS_RESP_OKAY;
            rdata_reg   <= `XBS_WORD_ZERO;
        end else if (ce) begin
            if (ar_take) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_word;
                rresp_reg   <= rd_hit ? `XBS_RESP_OKAY : `XBS_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end else if (!rvalid_reg) begin
                arready_reg <= 1'b1;
            end
        end
    end

    // outputs straight from flip-flops
    assign parallel_route_mem = sel_reg[`XBS_PAR_HOST_BIT];
    assign host_route_mux8    = sel_reg[`XBS_PAR_HOST_BIT];
    assign serial_route_bsp   = sel_reg[`XBS_SERIAL_BIT];
    assign periph_clk_en      = gi.clk_en;
    assign periph_bus_err     = gi.bus_err;
    assign irq                = irq_reg;
    assign s_axi_awready      = awready_reg;
    assign s_axi_wready       = wready_reg;
    assign s_axi_bvalid       = bvalid_reg;
    assign s_axi_bresp        = bresp_reg;
    assign s_axi_arready      = arready_reg;
    assign s_axi_rvalid       = rvalid_reg;
    assign s_axi_rresp        = rresp_reg;
    assign s_axi_rdata        = rdata_reg;

    // straps seen at the last reset edge define the modes after release
    a_strap_a_load:
    assert property ($rose(aresetn) |-> sel_reg[`XBS_PAR_HOST_BIT] == $past(strap_pin_a))
        else $error("parallel mode bit not loaded from strap A");

    a_strap_b_load:
    assert property ($rose(aresetn) |-> sel_reg[`XBS_SERIAL_BIT] == $past(strap_pin_b))
        else $error("serial mode bit not loaded from strap B");

    a_par_route:
    assert property (parallel_route_mem == host_route_mux8
                     && parallel_route_mem == sel_reg[`XBS_PAR_HOST_BIT])
        else $error("parallel and host routes disagree with mode bit");

    a_mode_held:
    assert property (!(ce && wr_sel) |=> $stable(sel_reg))
        else $error("mode bits moved without a register write");

    a_read_sel:
    assert property (ce && ar_take && s_axi_araddr == `XBS_ROUTE_SEL_ADDR
                     |=> rvalid_reg
                         && rdata_reg[`XBS_PAR_HOST_BIT] == $past(sel_reg[`XBS_PAR_HOST_BIT])
                         && rdata_reg[`XBS_SERIAL_BIT] == $past(sel_reg[`XBS_SERIAL_BIT])
                         && !rdata_reg[`XBS_RSVD_RO_BIT])
        else $error("route select read shows wrong mode");

    a_uart_sel:
    assert property (gi.selected[`XBS_P_UART] != gi.selected[`XBS_P_BSP])
        else $error("uart and serial port selected together");

    a_err_sticky:
    assert property (ce && |gi.bus_err |=> (stat_reg & $past(gi.bus_err)) == $past(gi.bus_err))
        else $error("bus error lost in status");

    a_irq_level:
    assert property ($past(ce) && $past(aresetn) |-> irq == $past(|(stat_reg & mask_reg)))
        else $error("interrupt does not follow masked status");

    a_write_resp:
    assert property (ce && do_write |=> bvalid_reg ##0 bvalid_reg[*1])
        else $error("write not answered");

    // a low clock enable freezes every software-visible register
    a_ce_freeze:
    assert property (!ce |=> $stable(sel_reg) && $stable(stat_reg) && $stable(mask_reg)
                     && $stable(tmo_en_reg) && $stable(irq_reg))
        else $error("state moved while clock enable was low");

    a_mask_write:
    assert property (ce && wr_mask && w_strb_reg[0]
                     |=> mask_reg == $past(w_data_reg[`XBS_NUM_PERIPH-1:0]))
        else $error("mask write did not land");

    a_stat_clear:
    assert property (ce && wr_stat && w_strb_reg[0] && !(|gi.bus_err)
                     |=> (stat_reg & $past(w_data_reg[`XBS_NUM_PERIPH-1:0])) == '0)
        else $error("status bit not cleared by a written one");

    a_read_done:
    assert property (ce && rvalid_reg && s_axi_rready |=> !rvalid_reg)
        else $error("read data stayed after its handshake");

    a_write_done:
    assert property (ce && bvalid_reg && s_axi_bready |=> !bvalid_reg)
        else $error("write response stayed after its handshake");
endmodule : xbs_route_top

// ---- dv/xbs_route_bench.sv ----
// self-checking bench for the external bus route select block
`timescale 1ns/10ps
`include "xbs_regs.svh"
module xbs_route_bench;
    // one row: straps at reset beside the routes they must give
    typedef struct packed {
        logic       strap_a;
        logic       strap_b;
        logic [2:0] exp_route;   // {parallel mem, host mux8, serial bsp}
        logic [2:0] exp_clk;     // {bsp, uart, mem}
        logic [3:0] exp_sel;
    } xbs_row_t;

    logic                     aclk;
    logic                     aresetn;
    logic                     ce;
    logic                     strap_pin_a;
    logic                     strap_pin_b;
    xbs_pkg::xbs_periph_vec_t periph_access;
    logic                     parallel_route_mem;
    logic                     host_route_mux8;
    logic                     serial_route_bsp;
    xbs_pkg::xbs_periph_vec_t periph_clk_en;
    xbs_pkg::xbs_periph_vec_t periph_bus_err;
    logic                     irq;
    xbs_pkg::xbs_addr_t       s_axi_awaddr;
    logic                     s_axi_awvalid;
    logic                     s_axi_awready;
    xbs_pkg::xbs_word_t       s_axi_wdata;
    logic [3:0]               s_axi_wstrb;
    logic                     s_axi_wvalid;
    logic                     s_axi_wready;
    logic [1:0]               s_axi_bresp;
    logic                     s_axi_bvalid;
    logic                     s_axi_bready;
    xbs_pkg::xbs_addr_t       s_axi_araddr;
    logic                     s_axi_arvalid;
    logic                     s_axi_arready;
    xbs_pkg::xbs_word_t       s_axi_rdata;
    logic [1:0]               s_axi_rresp;
    logic                     s_axi_rvalid;
    logic                     s_axi_rready;
    int                       fail_count;
    int                       cmp_count;
    int                       cycles;
    logic [1:0]               resp;
    xbs_pkg::xbs_word_t       rd;
    xbs_row_t                 rows [4];

    xbs_route_top xbs_route_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b),
        .periph_access(periph_access),
        .parallel_route_mem(parallel_route_mem), .host_route_mux8(host_route_mux8),
        .serial_route_bsp(serial_route_bsp), .periph_clk_en(periph_clk_en),
        .periph_bus_err(periph_bus_err), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    // 25 MHz clock
    initial aclk = 1'b0;
    always #20 aclk = ~aclk;

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles >= 3000) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    task automatic check(input string name, input xbs_pkg::xbs_word_t seen,
                         input xbs_pkg::xbs_word_t exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // address and data offered together, each dropped at its own handshake
    task automatic axi_write(input xbs_pkg::xbs_addr_t a, input xbs_pkg::xbs_word_t d,
                             output logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            if ((aw_done && w_done) && s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                break;
            end
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask : axi_write

    task automatic axi_read(input xbs_pkg::xbs_addr_t a, output xbs_pkg::xbs_word_t d,
                            output logic [1:0] r);
        bit taken;
        taken = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (taken && s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
            if (!taken && s_axi_arready === 1'b1) begin
                taken = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask : axi_read

    // reset with the row's straps, then move the straps so a late capture shows up
    task automatic run_row(input xbs_row_t row);
        @(posedge aclk);
        aresetn     <= 1'b0;
        strap_pin_a <= row.strap_a;
        strap_pin_b <= row.strap_b;
        repeat (3) @(posedge aclk);
        check("clk_en in reset", {29'h0, periph_clk_en}, 32'h0);
        check("awready in reset", {31'h0, s_axi_awready}, 32'h0);
        aresetn <= 1'b1;
        @(posedge aclk);
        strap_pin_a <= ~row.strap_a;
        strap_pin_b <= ~row.strap_b;
        repeat (3) @(posedge aclk);
        check("route", {29'h0, parallel_route_mem, host_route_mux8, serial_route_bsp},
              {29'h0, row.exp_route});
        check("clk_en", {29'h0, periph_clk_en}, {29'h0, row.exp_clk});
        axi_read(`XBS_ROUTE_SEL_ADDR, rd, resp);
        check("route sel", rd, {28'h0, row.exp_sel});
        check("route sel resp", {30'h0, resp}, 32'h0);
    endtask : run_row

    // one-cycle access burst, error must be a single pulse one cycle later
    task automatic pulse_access(input xbs_pkg::xbs_periph_vec_t v,
                                input xbs_pkg::xbs_periph_vec_t exp);
        @(posedge aclk);
        periph_access <= v;
        @(posedge aclk);
        periph_access <= 3'h0;
        @(posedge aclk);
        check("bus_err pulse", {29'h0, periph_bus_err}, {29'h0, exp});
        @(posedge aclk);
        check("bus_err after", {29'h0, periph_bus_err}, 32'h0);
    endtask : pulse_access

    // main sequence; responses are always accepted at once, wstrb stays full
    initial begin
        fail_count = 0;
        cmp_count = 0;
        cycles = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        strap_pin_a = 1'b1;
        strap_pin_b = 1'b1;
        periph_access = 3'h0;
        s_axi_awaddr = 16'h0000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 16'h0000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
        rows = '{'{1'b1, 1'b1, 3'h7, 3'h5, 4'h5}, '{1'b1, 1'b0, 3'h6, 3'h3, 4'h1},
                 '{1'b0, 1'b1, 3'h1, 3'h4, 4'h4}, '{1'b0, 1'b0, 3'h0, 3'h2, 4'h0}};
        foreach (rows[i]) run_row(rows[i]);
        // rewrite the route word with its own modes, reserved bit 3 zero, junk elsewhere
        axi_write(`XBS_ROUTE_SEL_ADDR, 32'hffff_fff2, resp);
        check("route sel wr resp", {30'h0, resp}, 32'h0);
        axi_read(`XBS_ROUTE_SEL_ADDR, rd, resp);
        check("route sel rewrite", rd, 32'h0);
        // last row leaves the memory interface and serial port deselected
        axi_read(`XBS_IRQ_STAT_ADDR, rd, resp);
        check("status reset", rd, 32'h0);
        axi_read(`XBS_IRQ_MASK_ADDR, rd, resp);
        check("mask reset", rd, 32'h0);
        axi_read(`XBS_CTRL_ADDR, rd, resp);
        check("ctrl reset", rd, 32'h0);
        pulse_access(3'h7, 3'h0);
        axi_write(`XBS_CTRL_ADDR, 32'h0000_0001, resp);
        axi_write(`XBS_IRQ_MASK_ADDR, 32'h0000_0001, resp);
        pulse_access(3'h7, 3'h5);
        axi_read(`XBS_IRQ_STAT_ADDR, rd, resp);
        check("status sticky", rd, 32'h0000_0005);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        // write-one-to-clear only the masked-in bit
        axi_write(`XBS_IRQ_STAT_ADDR, 32'h0000_0001, resp);
        repeat (2) @(posedge aclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        axi_read(`XBS_IRQ_STAT_ADDR, rd, resp);
        check("status left", rd, 32'h0000_0004);
        axi_write(`XBS_IRQ_MASK_ADDR, 32'h0000_0004, resp);
        repeat (2) @(posedge aclk);
        check("irq remask", {31'h0, irq}, 32'h1);
        axi_write(`XBS_IRQ_STAT_ADDR, 32'h0000_0004, resp);
        repeat (2) @(posedge aclk);
        check("irq final", {31'h0, irq}, 32'h0);
        // a low clock enable must swallow a deselected access
        @(posedge aclk);
        ce            <= 1'b0;
        periph_access <= 3'h7;
        repeat (2) @(posedge aclk);
        check("bus_err frozen", {29'h0, periph_bus_err}, 32'h0);
        ce            <= 1'b1;
        periph_access <= 3'h0;
        repeat (2) @(posedge aclk);
        check("bus_err thawed", {29'h0, periph_bus_err}, 32'h0);
        axi_read(`XBS_IRQ_STAT_ADDR, rd, resp);
        check("status frozen", rd, 32'h0);
        // an unmapped word answers with a slave error and reads zero
        axi_write(16'h6c10, 32'h0000_0001, resp);
        check("unmapped wr resp", {30'h0, resp}, {30'h0, `XBS_RESP_SLVERR});
        axi_read(16'h6c10, rd, resp);
        check("unmapped rd resp", {30'h0, resp}, {30'h0, `XBS_RESP_SLVERR});
        check("unmapped rd data", rd, 32'h0);
        tally_and_finish();
    end
endmodule : xbs_route_bench
